/* File: ddsc_pkg.sv */
/*
 * Constants shared by the synthesizer core: control bit positions, widths,
 * calibration lengths and multiplier limits.
 * Assumes nothing of its surroundings.
 */
package ddsc_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int TUNE_W = 32;
    localparam int PHASE_OFS_W = 16;
    localparam int SCALE_W = 12;
    localparam int AMP_W = 12;
    localparam int LUT_AW = 10;

    // ------------------------------------------------------------------
    // Control bit positions and status address
    // ------------------------------------------------------------------
    localparam int CTRL1_SINE_BIT = 16;
    localparam int CTRL1_OSC_CAL_BIT = 24;
    localparam int CTRL4_DAC_CAL_BIT = 24;
    localparam int STATUS_LOCK_BIT = 24;
    localparam logic [7:0] STATUS_ADDR = 8'h1B;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int MOD_DIV = 24;
    localparam int DAC_CAL_CYCLES = 469632;
    localparam int OSC_CAL_CYCLES = 1024;
    localparam int LOCK_CYCLES = 256;

    // ------------------------------------------------------------------
    // Multiplier limits
    // ------------------------------------------------------------------
    localparam logic [8:0] MULT_MIN = 9'h014;
    localparam logic [8:0] MULT_MAX = 9'h1FE;

    typedef enum logic [2:0] {
        CAL_IDLE = 3'b001,
        CAL_OSC = 3'b010,
        CAL_DAC = 3'b100
    } ddsc_cal_e;

endpackage

/* File: ddsc_sine_rom.sv */
/*
 * Quarter-wave sine lookup producing a signed 12-bit amplitude.
 * Assumes a registered phase address from the core; one cycle latency.
 */
`timescale 1ns/10ps
module ddsc_sine_rom
    import ddsc_pkg::*;
#(
    parameter int AW = LUT_AW,
    parameter int DW = AMP_W
) (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic [AW-1:0] phase_i,
    output logic signed [DW-1:0] amp_o
);

    localparam int QW = AW - 2;
    localparam int QN = 1 << QW;
    localparam real PI = 3.14159265358979;

    logic [DW-2:0] quarter [QN];
    logic [QW-1:0] idx;
    logic [DW-2:0] mag;

    // Table is filled by a loop in an initial block at time zero.
    initial begin
        for (int i = 0; i < QN; i++) begin
            quarter[i] = (DW-1)'($rtoi($sin(PI * (real'(i) + 0.5) / (2.0 * QN)) * ((1 << (DW - 1)) - 1)));
        end
    end

    // ------------------------------------------------------------------
    // Quadrant folding
    // ------------------------------------------------------------------
    assign idx = phase_i[AW-2] ? ~phase_i[QW-1:0] : phase_i[QW-1:0];
    assign mag = quarter[idx];

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            amp_o <= '0;
        end else begin
            amp_o <= phase_i[AW-1] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
        end
    end

endmodule

/* File: ddsc_core.sv */
/*
 * Synthesizer core: phase accumulator, phase offset, sine/cosine lookup,
 * amplitude scaling, clock-source selection, lock flag and calibration.
 * Assumes control bits come from same-clock register logic; the lock
 * detect input comes from an analog PLL and is synchronised here.
 */
// How it works
// (R1) Bit 16 of control word picks sine or cosine.
// (R2) Accumulator steps by tuning word each sample.
// (R3) Upper-half tuning words alias, never rejected.
// (R4) Phase offset added before amplitude lookup.
// (R5) Lookup output scaled by factor over 4096.
// (R6) Parameters load once every 24 cycles.
// (R7) Software pulses DAC calibration bit after clocks.
// (R8) DAC calibration lasts 469,632 sample periods.
// (R9) PLL enable picks multiplier or reference clock.
// (R10) Multiplier accepts even factors 20 to 510.
// (R11) Lock status at bit 24 of 0x1B.
// (R12) Software starts oscillator calibration when reference stable.
// (R13) Software clears calibration bit before restarting.
// (R14) Oscillator calibration precedes DAC calibration.
// (R15) Lock bit one only while locked.
// (R16) Calibration starts on rising enable edge only.
// (R17) Accumulator wraps; upper bits address lookup.
`timescale 1ns/10ps
module ddsc_core
    import ddsc_pkg::*;
#(
    parameter int DAC_CAL_LEN = DAC_CAL_CYCLES,
    parameter int OSC_CAL_LEN = OSC_CAL_CYCLES
) (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic [31:0] first_control_register_i,
    input wire logic [31:0] third_control_register_i,
    input wire logic [31:0] fourth_control_register_i,
    input wire logic pll_enable_i,
    input wire logic [8:0] pll_mult_i,
    input wire logic pll_lock_raw_i,
    input wire logic [TUNE_W-1:0] frequency_tuning_word_i,
    input wire logic [PHASE_OFS_W-1:0] phase_offset_word_i,
    input wire logic [SCALE_W-1:0] amplitude_scale_factor_i,
    input wire logic [7:0] status_addr_i,
    output logic signed [AMP_W-1:0] sample_o,
    output logic use_pll_o,
    output logic [8:0] pll_mult_o,
    output logic mult_ok_o,
    output logic [31:0] status_rdata_o,
    output logic pll_locked_o,
    output logic osc_cal_busy_o,
    output logic dac_cal_busy_o,
    output logic dac_cal_done_o,
    output logic mod_tick_o
);

    localparam int DIV_W = $clog2(MOD_DIV);
    localparam int CAL_W = $clog2(DAC_CAL_LEN + 1);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MOD_DIV - 1);
    localparam logic [CAL_W-1:0] DAC_LAST = CAL_W'(DAC_CAL_LEN - 1);
    localparam logic [CAL_W-1:0] OSC_LAST = CAL_W'(OSC_CAL_LEN - 1);
    localparam logic [PHASE_OFS_W-1:0] QUARTER = 16'h4000;

    // ------------------------------------------------------------------
    // Parameter update divider
    // ------------------------------------------------------------------
    logic [DIV_W-1:0] div_q;
    logic tick;
    assign tick = (div_q == DIV_LAST);

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            div_q <= '0;
        end else begin
            div_q <= tick ? '0 : div_q + 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mod_tick_o <= 1'b0;
        end else begin
            mod_tick_o <= tick;
        end
    end

    logic [TUNE_W-1:0] tune_q;
    logic [PHASE_OFS_W-1:0] phase_ofs_q;
    logic [SCALE_W-1:0] scale_q;
    logic cos_q;

    // Modulation parameters are taken only on the divider tick (see R6).
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tune_q <= '0;
            phase_ofs_q <= '0;
            scale_q <= '0;
            cos_q <= 1'b0;
        end else if (tick) begin
            tune_q <= frequency_tuning_word_i;
            phase_ofs_q <= phase_offset_word_i;
            scale_q <= amplitude_scale_factor_i;
            cos_q <= ~first_control_register_i[CTRL1_SINE_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Phase path
    // ------------------------------------------------------------------
    logic [TUNE_W-1:0] acc_q;
    logic [PHASE_OFS_W-1:0] phase_q;

    // Free-running modulo 2^32 sum; any word is accepted (see R2) (see R3) (see R17).
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            acc_q <= '0;
        end else begin
            acc_q <= acc_q + tune_q;
        end
    end

    // Offset plus a quarter turn when cosine is selected (see R4) (see R1).
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            phase_q <= '0;
        end else begin
            phase_q <= acc_q[TUNE_W-1 -: PHASE_OFS_W] + phase_ofs_q + (cos_q ? QUARTER : '0);
        end
    end

    logic signed [AMP_W-1:0] lut_amp;

    ddsc_sine_rom #(
        .AW(LUT_AW),
        .DW(AMP_W)
    ) u_rom (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .phase_i(phase_q[PHASE_OFS_W-1 -: LUT_AW]),
        .amp_o(lut_amp)
    );

    logic signed [AMP_W+SCALE_W:0] prod;
    assign prod = lut_amp * $signed({1'b0, scale_q});

    // Divide by 4096 keeps the fraction of full scale (see R5).
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sample_o <= '0;
        end else begin
            sample_o <= prod[SCALE_W +: AMP_W];
        end
    end

    // ------------------------------------------------------------------
    // Clock source and multiplier
    // ------------------------------------------------------------------
    logic mult_ok;
    assign mult_ok = !pll_mult_i[0] && pll_mult_i >= MULT_MIN && pll_mult_i <= MULT_MAX;

    // Source select and an even, in-range factor only (see R9) (see R10).
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            use_pll_o <= 1'b0;
            pll_mult_o <= MULT_MIN;
            mult_ok_o <= 1'b0;
        end else begin
            use_pll_o <= pll_enable_i;
            mult_ok_o <= mult_ok;
            if (mult_ok) begin
                pll_mult_o <= pll_mult_i;
            end
        end
    end

    logic lock_s1_q;
    logic lock_s2_q;

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            lock_s1_q <= 1'b0;
            lock_s2_q <= 1'b0;
        end else begin
            lock_s1_q <= pll_lock_raw_i;
            lock_s2_q <= lock_s1_q;
        end
    end

    logic locked;
    assign locked = pll_enable_i && lock_s2_q;

    // Lock reads one only while locked, at its status bit (see R15) (see R11).
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pll_locked_o <= 1'b0;
            status_rdata_o <= '0;
        end else begin
            pll_locked_o <= locked;
            status_rdata_o <= '0;
            if (status_addr_i == STATUS_ADDR) begin
                status_rdata_o[STATUS_LOCK_BIT] <= locked;
            end
        end
    end

    // ------------------------------------------------------------------
    // Calibration sequencer
    // ------------------------------------------------------------------
    logic osc_en_q;
    logic dac_en_q;
    logic osc_rise;
    logic dac_rise;
    assign osc_rise = first_control_register_i[CTRL1_OSC_CAL_BIT] && !osc_en_q;
    assign dac_rise = fourth_control_register_i[CTRL4_DAC_CAL_BIT] && !dac_en_q;

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            osc_en_q <= 1'b0;
            dac_en_q <= 1'b0;
        end else begin
            osc_en_q <= first_control_register_i[CTRL1_OSC_CAL_BIT];
            dac_en_q <= fourth_control_register_i[CTRL4_DAC_CAL_BIT];
        end
    end

    ddsc_cal_e cal_q;
    logic [CAL_W-1:0] cal_cnt_q;

    // A run starts only on an enable edge; a held bit starts nothing (see R16) (see R8).
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cal_q <= CAL_IDLE;
            cal_cnt_q <= '0;
        end else begin
            case (cal_q)
                CAL_IDLE: begin
                    cal_cnt_q <= '0;
                    if (osc_rise && pll_enable_i) begin
                        cal_q <= CAL_OSC;
                    end else if (dac_rise) begin
                        cal_q <= CAL_DAC;
                    end
                end
                CAL_OSC: begin
                    cal_cnt_q <= cal_cnt_q + 1'b1;
                    if (cal_cnt_q == OSC_LAST) begin
                        cal_q <= CAL_IDLE;
                    end
                end
                CAL_DAC: begin
                    cal_cnt_q <= cal_cnt_q + 1'b1;
                    if (cal_cnt_q == DAC_LAST) begin
                        cal_q <= CAL_IDLE;
                    end
                end
                default: begin
                    cal_q <= CAL_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            osc_cal_busy_o <= 1'b0;
            dac_cal_busy_o <= 1'b0;
            dac_cal_done_o <= 1'b0;
        end else begin
            osc_cal_busy_o <= (cal_q == CAL_OSC) && !(cal_cnt_q == OSC_LAST);
            dac_cal_busy_o <= (cal_q == CAL_DAC) && !(cal_cnt_q == DAC_LAST);
            if (cal_q == CAL_DAC && cal_cnt_q == DAC_LAST) begin
                dac_cal_done_o <= 1'b1;
            end else if (cal_q == CAL_IDLE && dac_rise) begin
                dac_cal_done_o <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    chk_param_hold: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // see R6
        !$past(tick) |-> $stable(tune_q))
        else $error("tuning word changed off tick");
    chk_acc_step: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // see R2
        ##1 acc_q == $past(acc_q) + $past(tune_q))
        else $error("accumulator step wrong");
    chk_tick_period: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // see R6
        tick |=> !tick [*8])
        else $error("divider tick too soon");
    chk_scale_zero: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // see R5
        (scale_q == '0) [*4] |-> sample_o == '0)
        else $error("zero scale not silent");
    chk_lock_status: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // see R15
        locked |=> pll_locked_o)
        else $error("lock not reported");
    chk_lock_addr: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // see R11
        (status_addr_i == STATUS_ADDR && locked) |=> status_rdata_o[STATUS_LOCK_BIT])
        else $error("lock bit missing at status address");
    chk_mult_even: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // see R10
        !pll_mult_o[0] && pll_mult_o >= MULT_MIN && pll_mult_o <= MULT_MAX)
        else $error("multiplier out of range");
    chk_cal_edge: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // see R16
        (cal_q == CAL_IDLE && !osc_rise && !dac_rise) |=> cal_q == CAL_IDLE)
        else $error("calibration started without edge");
    chk_dac_len: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // see R8
        (cal_q == CAL_DAC && cal_cnt_q == DAC_LAST) |=> cal_q == CAL_IDLE && dac_cal_done_o)
        else $error("DAC calibration length wrong");
    chk_source_sel: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // see R9
        ##1 use_pll_o == $past(pll_enable_i))
        else $error("clock source not followed");

    cov_dac_cal: cover property (@(posedge core_clk_i) disable iff (!nrst_i) cal_q == CAL_DAC);
    cov_osc_cal: cover property (@(posedge core_clk_i) disable iff (!nrst_i) cal_q == CAL_OSC);
    cov_locked: cover property (@(posedge core_clk_i) disable iff (!nrst_i) pll_locked_o);
    cov_alias: cover property (@(posedge core_clk_i) disable iff (!nrst_i) tune_q[TUNE_W-1]);

endmodule

/* File: dds_core_with_calibration_test.sv */
/*
 * Self-checking testbench for the synthesizer core: multiplier limits, lock
 * report, modulation tick, calibration sequencing and the sample datapath.
 * Assumes the core and its package are compiled first; it drives every port.
 */
`timescale 1ns/10ps
module dds_core_with_calibration_test;
    import ddsc_pkg::*;
    localparam int DAC_LEN = 50;
    localparam int OSC_LEN = 16;
    logic core_clk_i, nrst_i, pll_enable_i, pll_lock_raw_i;
    logic [31:0] first_control_register_i, third_control_register_i, fourth_control_register_i;
    logic [8:0] pll_mult_i;
    logic [TUNE_W-1:0] frequency_tuning_word_i;
    logic [PHASE_OFS_W-1:0] phase_offset_word_i;
    logic [SCALE_W-1:0] amplitude_scale_factor_i;
    logic [7:0] status_addr_i;
    logic signed [AMP_W-1:0] sample_o;
    logic use_pll_o, mult_ok_o, pll_locked_o, osc_cal_busy_o, dac_cal_busy_o, dac_cal_done_o, mod_tick_o;
    logic [8:0] pll_mult_o;
    logic [31:0] status_rdata_o;
    int miscompares = 0;
    int samples_checked = 0;

    ddsc_core #(.DAC_CAL_LEN(DAC_LEN), .OSC_CAL_LEN(OSC_LEN)) uut (
        .core_clk_i(core_clk_i), .nrst_i(nrst_i),
        .first_control_register_i(first_control_register_i),
        .third_control_register_i(third_control_register_i),
        .fourth_control_register_i(fourth_control_register_i),
        .pll_enable_i(pll_enable_i), .pll_mult_i(pll_mult_i), .pll_lock_raw_i(pll_lock_raw_i),
        .frequency_tuning_word_i(frequency_tuning_word_i), .phase_offset_word_i(phase_offset_word_i),
        .amplitude_scale_factor_i(amplitude_scale_factor_i), .status_addr_i(status_addr_i),
        .sample_o(sample_o), .use_pll_o(use_pll_o), .pll_mult_o(pll_mult_o), .mult_ok_o(mult_ok_o),
        .status_rdata_o(status_rdata_o), .pll_locked_o(pll_locked_o), .osc_cal_busy_o(osc_cal_busy_o),
        .dac_cal_busy_o(dac_cal_busy_o), .dac_cal_done_o(dac_cal_done_o), .mod_tick_o(mod_tick_o)
    );

    // ------------------------------------------------------------------
    // Clock, helpers and compares
    // ------------------------------------------------------------------
    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end

    task automatic step(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask

    task automatic print_verdict();
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_diff(input logic [31:0] got, input logic [31:0] other);
        samples_checked++;
        if (got === other) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, ~other);
        end
    endtask

    function automatic logic sig(input int sel);
        case (sel)
            0: return osc_cal_busy_o;
            1: return dac_cal_busy_o;
            default: return mod_tick_o;
        endcase
    endfunction

    task automatic wait_for(input int sel);
        for (int i = 0; i < 600 && sig(sel) !== 1'b1; i++) step(1);
        if (sig(sel) !== 1'b1) begin
            miscompares++;
            print_verdict();
        end
    endtask

    task automatic meas(input int sel, output int n);
        wait_for(sel);
        n = 0;
        for (int i = 0; i < 1000 && sig(sel) === 1'b1; i++) begin
            n++;
            step(1);
        end
    endtask

    task automatic count_high(input int sel, input int cycles, output int n);
        n = 0;
        repeat (cycles) begin
            if (sig(sel) === 1'b1) n++;
            step(1);
        end
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_mult();
        logic [8:0] req [7] = '{9'h014, 9'h1FE, 9'h015, 9'h012, 9'h064, 9'h1FF, 9'h000};
        logic [6:0] ok = 7'b0010011;
        logic [8:0] hold [7] = '{9'h014, 9'h1FE, 9'h1FE, 9'h1FE, 9'h064, 9'h064, 9'h064};
        for (int i = 0; i < 7; i++) begin
            pll_mult_i = req[i];
            step(2);
            check_val(32'(mult_ok_o), 32'(ok[i]));
            check_val(32'(pll_mult_o), 32'(hold[i]));
        end
    endtask

    task automatic t_lock();
        pll_enable_i = 1'b1;
        pll_lock_raw_i = 1'b1;
        status_addr_i = STATUS_ADDR;
        step(6);
        check_val(32'(use_pll_o), 32'h0000_0001);
        check_val(32'(pll_locked_o), 32'h0000_0001);
        check_val(status_rdata_o, 32'h0100_0000);
        status_addr_i = 8'h1A;
        step(2);
        check_val(status_rdata_o, 32'h0000_0000);
        status_addr_i = STATUS_ADDR;
        pll_lock_raw_i = 1'b0;
        step(6);
        check_val(status_rdata_o, 32'h0000_0000);
        pll_lock_raw_i = 1'b1;
        pll_enable_i = 1'b0;
        step(6);
        check_val(32'(use_pll_o), 32'h0000_0000);
        check_val(32'(pll_locked_o), 32'h0000_0000);
    endtask

    task automatic t_tick();
        int n;
        wait_for(2);
        repeat (2) begin
            step(1);
            n = 1;
            for (int i = 0; i < 40 && mod_tick_o !== 1'b1; i++) begin
                n++;
                step(1);
            end
            check_val(32'(n), 32'(MOD_DIV));
        end
    endtask

    task automatic t_cal();
        int n;
        first_control_register_i[24] = 1'b1;
        count_high(0, OSC_LEN + 4, n);
        check_val(32'(n), 32'h0000_0000);
        first_control_register_i[24] = 1'b0;
        pll_enable_i = 1'b1;
        step(2);
        first_control_register_i[24] = 1'b1;
        wait_for(0);
        fourth_control_register_i[24] = 1'b1;
        meas(0, n);
        check_val(32'(n + 1), 32'(OSC_LEN));
        count_high(1, DAC_LEN + 8, n);
        check_val(32'(n), 32'h0000_0000);
        count_high(0, 8, n);
        check_val(32'(n), 32'h0000_0000);
        fourth_control_register_i[24] = 1'b0;
        step(2);
        fourth_control_register_i[24] = 1'b1;
        meas(1, n);
        check_val(32'(n + 1), 32'(DAC_LEN));
        step(2);
        check_val(32'(dac_cal_done_o), 32'h0000_0001);
        count_high(1, 60, n);
        check_val(32'(n), 32'h0000_0000);
        fourth_control_register_i[24] = 1'b0;
        step(2);
        fourth_control_register_i[24] = 1'b1;
        wait_for(1);
        check_val(32'(dac_cal_done_o), 32'h0000_0000);
        meas(1, n);
        check_val(32'(n + 1), 32'(DAC_LEN));
        first_control_register_i[24] = 1'b0;
        fourth_control_register_i[24] = 1'b0;
    endtask

    task automatic settle(input logic sine, input logic [31:0] tune, input logic [15:0] pw, input logic [11:0] scale);
        first_control_register_i[16] = sine;
        frequency_tuning_word_i = tune;
        phase_offset_word_i = pw;
        amplitude_scale_factor_i = scale;
        step(MOD_DIV + 12);
    endtask

    task automatic t_wave();
        logic [31:0] tune [4] = '{32'h8000_0000, 32'h4000_0000, 32'hC000_0000, 32'h2000_0000};
        int per [4] = '{2, 4, 4, 8};
        logic signed [11:0] s [16];
        logic signed [11:0] a;
        for (int k = 0; k < 4; k++) begin
            settle(1'b0, tune[k], 16'h0000, 12'hFFF);
            for (int i = 0; i < 16; i++) begin
                s[i] = sample_o;
                step(1);
            end
            check_diff(32'(s[1]), 32'(s[0]));
            for (int i = 0; i < 8; i++) check_val(32'(s[i + per[k]]), 32'(s[i]));
        end
        settle(1'b0, 32'h0000_0000, 16'h0000, 12'h800);
        a = sample_o;
        check_diff(32'(a), 32'h0000_0000);
        settle(1'b0, 32'h0000_0000, 16'h0000, 12'h400);
        check_val(32'(sample_o), 32'(a >>> 1));
        settle(1'b1, 32'h0000_0000, 16'h4000, 12'h800);
        check_val(32'(sample_o), 32'(a));
        settle(1'b1, 32'h0000_0000, 16'h0000, 12'h800);
        check_diff(32'(sample_o), 32'(a));
        settle(1'b0, 32'h0000_0000, 16'h0000, 12'h000);
        check_val(32'(sample_o), 32'h0000_0000);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        nrst_i = 1'b0;
        first_control_register_i = 32'h0000_0000;
        third_control_register_i = 32'h0000_0000;
        fourth_control_register_i = 32'h0000_0000;
        pll_enable_i = 1'b0;
        pll_mult_i = 9'h014;
        pll_lock_raw_i = 1'b0;
        frequency_tuning_word_i = 32'h0000_0000;
        phase_offset_word_i = 16'h0000;
        amplitude_scale_factor_i = 12'h000;
        status_addr_i = 8'h00;
        step(8);
        check_val(32'(pll_mult_o), 32'h0000_0014);
        check_val(32'(dac_cal_busy_o), 32'h0000_0000);
        nrst_i = 1'b1;
        t_mult();
        t_lock();
        t_tick();
        t_cal();
        t_wave();
        print_verdict();
    end
endmodule
